// ==== hdl/sbns_map.svh ====
/*
 * Constants for the subtract-with-borrow and nibble-swap datapath:
 * field positions, reset values, address limits and phase timing.
 * Assumes it is included by its bare name from the core, the checker and the bench.
 */
`ifndef SBNS_MAP_SVH
`define SBNS_MAP_SVH

// ****************************************************************
// Register offsets (AXI4-Lite byte addresses)
// ****************************************************************
`define SBNS_OFF_CTRL 8'h00
`define SBNS_OFF_WREG 8'h04
`define SBNS_OFF_STATUS 8'h08
`define SBNS_OFF_BANK 8'h0C
`define SBNS_OFF_INSTR 8'h10
`define SBNS_OFF_RESULT 8'h14
`define SBNS_OFF_ADDR 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define SBNS_CTRL_EXT_BIT 0
`define SBNS_INSTR_FILE_LSB 0
`define SBNS_INSTR_ACC_BIT 8
`define SBNS_INSTR_DEST_BIT 9
`define SBNS_INSTR_OP_BIT 10
`define SBNS_ST_C 0
`define SBNS_ST_DIGIT_CARRY 1
`define SBNS_ST_Z 2
`define SBNS_ST_OVERFLOW 3
`define SBNS_ST_N 4
`define SBNS_ST_BUSY 8

// ****************************************************************
// Address formation and reset values
// ****************************************************************
`define SBNS_LIT_OFF_MAX 8'h5F
`define SBNS_ACC_LOW_MAX 8'h5F
`define SBNS_ACC_HIGH_BANK 4'hF
`define SBNS_WREG_RST 8'h00
`define SBNS_FLAGS_RST 5'h00
`define SBNS_BANK_RST 4'h0
`define SBNS_INDEX_BASE_RST 12'h000
`define SBNS_MEM_DEPTH 4096

// ****************************************************************
// Timing and bus response codes
// ****************************************************************
`define SBNS_Q_PHASES 4
`define SBNS_AXI_RESP_OKAY 2'h0
`define SBNS_AXI_RESP_SLVERR 2'h2

`endif

// ==== hdl/sbns_pkg.sv ====
/*
 * Types for the subtract-with-borrow and nibble-swap datapath.
 * Assumes sbns_map.svh sits on the include path.
 */
package sbns_pkg;

	// ****************************************************************
	// Idle state and the quarter phases of one instruction cycle
	// ****************************************************************
	typedef enum logic [2:0] {
		SBNS_IDLE,
		SBNS_Q1_DECODE,
		SBNS_Q2_READ,
		SBNS_Q3_PROCESS,
		SBNS_Q4_WRITE
	} sbns_phase_t;

	// Instruction selector carried in the instruction word.
	typedef enum logic {
		SBNS_OP_SUB_BORROW,
		SBNS_OP_SWAP
	} sbns_op_t;

	// Whole state of the top module except the file memory contents.
	typedef struct packed {
		sbns_phase_t phase;
		sbns_op_t op;
		logic dest_file;
		logic acc_bank;
		logic [7:0] file_field;
		logic [11:0] addr;
		logic [7:0] operand;
		logic [7:0] result;
		logic [4:0] flags;
		logic [7:0] wreg;
		logic [3:0] bank;
		logic [11:0] index_base;
		logic ext_enable;
		logic mem_we;
		logic [7:0] mem_wdata;
		logic awvalid_seen;
		logic [7:0] awaddr;
		logic wvalid_seen;
		logic [31:0] wdata;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic busy;
	} sbns_state_t;

endpackage : sbns_pkg

// ==== hdl/sbns_file_mem.sv ====
/*
 * Data memory of 4096 bytes holding the file registers.
 * Read data come out of a register one clock after the address.
 * Assumes a single clock; write and read in one cycle return the old byte.
 */
`timescale 1ns/1ns
module sbns_file_mem
(
	input wire logic aclk, // Core clock.
	input wire logic [11:0] addr, // Byte address.
	input wire logic we, // Write strobe.
	input wire logic [7:0] wdata, // Byte to store.
	output logic [7:0] rdata // Registered read data.
);

	// Power-up contents are zero so a run starts from a known file; nothing clears them later.
	logic [7:0] mem [0:4095] = '{default: 8'h00};

	// Synchronous write and registered read; no reset so it maps to block memory.
	always_ff @(posedge aclk)
	begin
		if (we)
		begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : sbns_file_mem

// ==== hdl/sbns_core.sv ====
/*
 * Execution datapath for subtract-with-borrow and nibble swap on one byte
 * of file memory, driven by software over AXI4-Lite.
 * Assumes one 25 MHz clock, a synchronous active-low reset, and a master
 * that keeps at most one write and one read outstanding.
 */
// How it works
// - Result is file minus W minus inverted carry.
// - Destination bit 1 writes file, 0 writes W.
// - Access bit 1 uses bank register plus field.
// - Extended set, access 0, field<=5Fh: indexed offset.
// - Subtract updates negative, overflow, carry, digit carry, zero.
// - Four quarter phases: decode, read, process, write.
// - Access 0 otherwise addresses the access bank.
`timescale 1ns/1ns
`include "sbns_map.svh"
module sbns_core
(
	input wire logic aclk, // Core clock, 25 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte enables.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output logic busy // High while an instruction is in its phases.
);

	sbns_pkg::sbns_state_t st_reg;
	sbns_pkg::sbns_state_t st_next;
	logic [7:0] mem_rdata;
	logic [11:0] mem_addr;

	// ****************************************************************
	// File memory
	// ****************************************************************
	// The memory address follows the latched operand address so that the
	// write in the fourth phase lands on the byte read in the second.
	assign mem_addr = st_reg.addr;

	sbns_file_mem u_mem
	(
		.aclk(aclk),
		.addr(mem_addr),
		.we(st_reg.mem_we),
		.wdata(st_reg.mem_wdata),
		.rdata(mem_rdata)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// Bus slave and instruction sequencer share one combinational process.
	always_comb
	begin
		logic [8:0] diff;
		logic [4:0] low_diff;
		logic [7:0] res;
		logic borrow_in;
		logic wr_go;
		logic [7:0] wr_addr;
		logic [31:0] wr_data;
		st_next = st_reg;
		diff = 9'h000;
		low_diff = 5'h00;
		res = 8'h00;
		borrow_in = 1'b0;
		wr_go = 1'b0;
		wr_addr = 8'h00;
		wr_data = 32'h0000_0000;
		st_next.mem_we = 1'b0;
		st_next.awready = 1'b0;
		st_next.wready = 1'b0;
		st_next.arready = 1'b0;

		// Write channel: address and data are taken independently, in any order.
		if (s_axi_awvalid && !st_reg.awvalid_seen && !st_reg.bvalid)
		begin
			st_next.awready = 1'b1;
			if (st_reg.awready)
			begin
				st_next.awready = 1'b0;
				st_next.awvalid_seen = 1'b1;
				st_next.awaddr = s_axi_awaddr;
			end
		end
		if (s_axi_wvalid && !st_reg.wvalid_seen && !st_reg.bvalid)
		begin
			st_next.wready = 1'b1;
			if (st_reg.wready)
			begin
				st_next.wready = 1'b0;
				st_next.wvalid_seen = 1'b1;
				st_next.wdata = s_axi_wdata;
			end
		end
		// A write that lands while an instruction runs waits, so no field
		// changes under the datapath mid-cycle.
		if (st_reg.awvalid_seen && st_reg.wvalid_seen && !st_reg.bvalid
			&& st_reg.phase == sbns_pkg::SBNS_IDLE)
		begin
			wr_go = 1'b1;
			wr_addr = st_reg.awaddr;
			wr_data = st_reg.wdata;
		end
		if (wr_go)
		begin
			st_next.awvalid_seen = 1'b0;
			st_next.wvalid_seen = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `SBNS_AXI_RESP_OKAY;
			unique case (wr_addr)
				`SBNS_OFF_CTRL:
				begin
					if (s_axi_wstrb[0])
					begin
						st_next.ext_enable = wr_data[`SBNS_CTRL_EXT_BIT];
					end
				end
				`SBNS_OFF_WREG:
				begin
					if (s_axi_wstrb[0])
					begin
						st_next.wreg = wr_data[7:0];
					end
				end
				`SBNS_OFF_STATUS:
				begin
					if (s_axi_wstrb[0])
					begin
						st_next.flags = wr_data[4:0];
					end
				end
				`SBNS_OFF_BANK:
				begin
					if (s_axi_wstrb[0])
					begin
						st_next.bank = wr_data[3:0];
					end
				end
				`SBNS_OFF_ADDR:
				begin
					st_next.index_base = wr_data[11:0];
				end
				`SBNS_OFF_INSTR:
				begin
					// Writing the instruction word starts the decode phase.
					st_next.file_field = wr_data[`SBNS_INSTR_FILE_LSB +: 8];
					st_next.acc_bank = wr_data[`SBNS_INSTR_ACC_BIT];
					st_next.dest_file = wr_data[`SBNS_INSTR_DEST_BIT];
					st_next.op = sbns_pkg::sbns_op_t'(wr_data[`SBNS_INSTR_OP_BIT]);
					st_next.phase = sbns_pkg::SBNS_Q1_DECODE;
				end
				default:
				begin
					st_next.bresp = `SBNS_AXI_RESP_SLVERR;
				end
			endcase
		end
		if (st_reg.bvalid && s_axi_bready)
		begin
			st_next.bvalid = 1'b0;
		end

		// Read channel: one read at a time, answered the cycle after acceptance.
		if (s_axi_arvalid && !st_reg.rvalid && !st_reg.arready)
		begin
			st_next.arready = 1'b1;
		end
		if (st_reg.arready)
		begin
			st_next.rvalid = 1'b1;
			st_next.rresp = `SBNS_AXI_RESP_OKAY;
			st_next.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				`SBNS_OFF_CTRL: st_next.rdata[0] = st_reg.ext_enable;
				`SBNS_OFF_WREG: st_next.rdata[7:0] = st_reg.wreg;
				`SBNS_OFF_STATUS:
				begin
					st_next.rdata[4:0] = st_reg.flags;
					st_next.rdata[`SBNS_ST_BUSY] = (st_reg.phase != sbns_pkg::SBNS_IDLE);
				end
				`SBNS_OFF_BANK: st_next.rdata[3:0] = st_reg.bank;
				`SBNS_OFF_INSTR:
				begin
					st_next.rdata[7:0] = st_reg.file_field;
					st_next.rdata[`SBNS_INSTR_ACC_BIT] = st_reg.acc_bank;
					st_next.rdata[`SBNS_INSTR_DEST_BIT] = st_reg.dest_file;
					st_next.rdata[`SBNS_INSTR_OP_BIT] = st_reg.op;
				end
				`SBNS_OFF_RESULT: st_next.rdata[7:0] = st_reg.result;
				`SBNS_OFF_ADDR: st_next.rdata[11:0] = st_reg.index_base;
				default: st_next.rresp = `SBNS_AXI_RESP_SLVERR;
			endcase
		end
		if (st_reg.rvalid && s_axi_rready)
		begin
			st_next.rvalid = 1'b0;
		end

		// Instruction sequencer, one state per quarter phase.
		unique case (st_reg.phase)
			sbns_pkg::SBNS_IDLE:
			begin
			end
			sbns_pkg::SBNS_Q1_DECODE:
			begin
				// Decode: form the operand address.
				if (st_reg.acc_bank)
				begin
					st_next.addr = {st_reg.bank, st_reg.file_field};
				end
				else if (st_reg.ext_enable && st_reg.file_field <= `SBNS_LIT_OFF_MAX)
				begin
					st_next.addr = st_reg.index_base + {4'h0, st_reg.file_field};
				end
				else if (st_reg.file_field <= `SBNS_ACC_LOW_MAX)
				begin
					st_next.addr = {4'h0, st_reg.file_field};
				end
				else
				begin
					st_next.addr = {`SBNS_ACC_HIGH_BANK, st_reg.file_field};
				end
				st_next.phase = sbns_pkg::SBNS_Q2_READ;
			end
			sbns_pkg::SBNS_Q2_READ:
			begin
				// The memory presents the addressed byte on this edge.
				st_next.phase = sbns_pkg::SBNS_Q3_PROCESS;
			end
			sbns_pkg::SBNS_Q3_PROCESS:
			begin
				st_next.operand = mem_rdata;
				if (st_reg.op == sbns_pkg::SBNS_OP_SUB_BORROW)
				begin
					borrow_in = ~st_reg.flags[`SBNS_ST_C];
					diff = {1'b0, mem_rdata} - {1'b0, st_reg.wreg} - {8'h00, borrow_in};
					low_diff = {1'b0, mem_rdata[3:0]} - {1'b0, st_reg.wreg[3:0]}
						- {4'h0, borrow_in};
					res = diff[7:0];
					// Carry and digit carry are active-low borrows.
					st_next.flags[`SBNS_ST_C] = ~diff[8];
					st_next.flags[`SBNS_ST_DIGIT_CARRY] = ~low_diff[4];
					st_next.flags[`SBNS_ST_Z] = (res == 8'h00);
					st_next.flags[`SBNS_ST_N] = res[7];
					st_next.flags[`SBNS_ST_OVERFLOW] = (mem_rdata[7] ^ st_reg.wreg[7])
						& (mem_rdata[7] ^ res[7]);
				end
				else
				begin
					res = {mem_rdata[3:0], mem_rdata[7:4]};
				end
				st_next.result = res;
				st_next.phase = sbns_pkg::SBNS_Q4_WRITE;
			end
			sbns_pkg::SBNS_Q4_WRITE:
			begin
				if (st_reg.dest_file)
				begin
					st_next.mem_we = 1'b1;
					st_next.mem_wdata = st_reg.result;
				end
				else
				begin
					st_next.wreg = st_reg.result;
				end
				st_next.phase = sbns_pkg::SBNS_IDLE;
			end
		endcase

		// Busy is kept in a flop of its own so the port comes straight from a register.
		st_next.busy = (st_next.phase != sbns_pkg::SBNS_IDLE);

		if (!aresetn)
		begin
			st_next = '0;
			st_next.phase = sbns_pkg::SBNS_IDLE;
			st_next.wreg = `SBNS_WREG_RST;
			st_next.flags = `SBNS_FLAGS_RST;
			st_next.bank = `SBNS_BANK_RST;
			st_next.index_base = `SBNS_INDEX_BASE_RST;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge aclk)
	begin
		st_reg <= st_next;
	end

	// Outputs come straight from the state register.
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign busy = st_reg.busy;

endmodule : sbns_core

// ==== verif/sbns_core_properties.sv ====
/* Port checks for sbns_core, bound to every instance.
   Assumes it sees only the core's ports; the read address is taken at its handshake. */
`timescale 1ns/1ns
`include "sbns_map.svh"
module sbns_core_props
(
	input wire logic aclk, // Core clock.
	input wire logic aresetn, // Reset, active low.
	input wire logic s_axi_awready, // Write address ready.
	input wire logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [1:0] s_axi_bresp, // Write response.
	input wire logic s_axi_arvalid, // Read address valid.
	input wire logic s_axi_arready, // Read address ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic [1:0] s_axi_rresp, // Read response.
	input wire logic busy // Instruction running.
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Four quarter phases, then idle.
	a_phase_count: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
		else $error("busy length wrong");
	a_start_ack: assert property ($rose(busy) |-> s_axi_bvalid)
		else $error("start without response");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held after handshake");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than a cycle");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("rvalid late");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held after handshake");
	// The master may move araddr once it is taken, so keep the accepted one.
	logic [7:0] araddr_q;
	always_ff @(posedge aclk)
	begin
		if (s_axi_arvalid && s_axi_arready)
		begin
			araddr_q <= s_axi_araddr;
		end
	end

	// Unaligned offsets and those past the map answer with an error, the rest with okay.
	a_rresp_map: assert property (s_axi_rvalid && (araddr_q > `SBNS_OFF_ADDR
		|| araddr_q[1:0] != 2'h0) |-> s_axi_rresp == `SBNS_AXI_RESP_SLVERR)
		else $error("unmapped read not refused");
	a_rresp_ok: assert property (s_axi_rvalid && araddr_q <= `SBNS_OFF_ADDR
		&& araddr_q[1:0] == 2'h0 |-> s_axi_rresp == `SBNS_AXI_RESP_OKAY)
		else $error("mapped read refused");
	a_reset_idle: assert property ($rose(aresetn) |-> !busy && !s_axi_bvalid && !s_axi_rvalid)
		else $error("not idle after reset");

	c_run: cover property ($rose(busy));
	c_bad_wr: cover property (s_axi_bvalid && s_axi_bresp == `SBNS_AXI_RESP_SLVERR);
	c_bad_rd: cover property (s_axi_rvalid && s_axi_rresp == `SBNS_AXI_RESP_SLVERR);
endmodule : sbns_core_props

bind sbns_core sbns_core_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .busy);

// ==== verif/subtract_borrow_nibble_swap_tb.sv ====
/* Self-checking bench for sbns_core, driven over AXI4-Lite by tasks.
   Assumes the design and the checker are compiled before it. */
`timescale 1ns/1ns
`include "sbns_map.svh"
module subtract_borrow_nibble_swap_tb;
	localparam logic [31:0] w_tab = 32'h017F0000;
	localparam logic [3:0] c_bits = 4'hD;
	localparam logic [3:0] d_bits = 4'h6;
	logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv, busy;
	logic [7:0] awa, ara, f, w, v;
	logic [31:0] wd, rdat, r;
	logic [1:0] br, rr, rs;
	logic [12:0] m;
	int n_fail, checks;

	sbns_core u_dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .busy(busy)
	);

	// ****************************************************************
	// Bus tasks and reference
	// ****************************************************************
	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	// Address and data go out together; bready stays up until the response.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) break;
		end
		resp = br;
		bry <= 1'b0;
		@(posedge aclk);
	endtask : wr

	// The address is held until rvalid; the slave samples it at the handshake.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		d = rdat;
		resp = rr;
		rry <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic exec(input logic op, input logic d, input logic a, input logic [7:0] fld);
		wr(`SBNS_OFF_INSTR, {21'h0, op, d, a, fld}, rs);
		while (busy)
			@(posedge aclk);
	endtask : exec

	// File memory is not on the bus, so the bench reads it through a swap into W.
	task automatic peek(input logic a, input logic [7:0] fld, output logic [7:0] val);
		exec(1'b1, 1'b0, a, fld);
		rd(`SBNS_OFF_WREG, r, rs);
		val = {r[3:0], r[7:4]};
	endtask : peek

	// Subtracting a byte from itself with borrow leaves FFh in the file.
	task automatic setff(input logic a, input logic [7:0] fld);
		peek(a, fld, f);
		wr(`SBNS_OFF_WREG, {24'h0, f}, rs);
		wr(`SBNS_OFF_STATUS, 32'h0, rs);
		exec(1'b0, 1'b1, a, fld);
	endtask : setff

	function automatic logic [12:0] model(input logic [7:0] fv, input logic [7:0] wv_, input logic c);
		logic [8:0] res;
		logic [4:0] lo;
		res = {1'b0, fv} - {1'b0, wv_} - {8'h00, ~c};
		lo = {1'b0, fv[3:0]} - {1'b0, wv_[3:0]} - {4'h0, ~c};
		return {res[7], (fv[7] != wv_[7]) && (res[7] != fv[7]), res[7:0] == 8'h00, ~lo[4],
			~res[8], res[7:0]};
	endfunction : model

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// ****************************************************************
	// Clock, watchdog and sequence
	// ****************************************************************
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// The sequence needs under two thousand cycles; ten times that means a hang.
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		complete_run();
	end

	initial
	begin
		{aresetn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
		n_fail = 0;
		checks = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int k = 0; k < 4; k++)
		begin
			rd(8'(k * 4), r, rs);
			cmp("reset value", 32'h0, r);
		end
		wr(8'h1C, 32'h1, rs);
		cmp("bresp", {30'h0, `SBNS_AXI_RESP_SLVERR}, {30'h0, rs});
		rd(8'h1C, r, rs);
		cmp("rresp", {30'h0, `SBNS_AXI_RESP_SLVERR}, {30'h0, rs});
		// Zero, minus one, 80h and signed overflow on a file byte that powers up at zero.
		wr(`SBNS_OFF_BANK, 32'h2, rs);
		for (int i = 0; i < 4; i++)
		begin
			peek(1'b1, 8'h34, f);
			w = (i < 2) ? f : w_tab[i * 8 +: 8];
			wr(`SBNS_OFF_WREG, {24'h0, w}, rs);
			wr(`SBNS_OFF_STATUS, {27'h0, 4'hA, c_bits[i]}, rs);
			m = model(f, w, c_bits[i]);
			exec(1'b0, d_bits[i], 1'b1, 8'h34);
			rd(`SBNS_OFF_STATUS, r, rs);
			cmp("status", {27'h0, m[12:8]}, r);
			rd(`SBNS_OFF_RESULT, r, rs);
			cmp("result", {24'h0, m[7:0]}, r);
			rd(`SBNS_OFF_WREG, r, rs);
			cmp("wreg", {24'h0, d_bits[i] ? w : m[7:0]}, r);
			peek(1'b1, 8'h34, v);
			cmp("file", {24'h0, d_bits[i] ? m[7:0] : f}, {24'h0, v});
		end
		rd(`SBNS_OFF_STATUS, r, rs);
		cmp("swap flags", {27'h0, m[12:8]}, r);
		rd(`SBNS_OFF_RESULT, r, rs);
		cmp("swap result", 32'h08, r);
		// Indexed base 200h plus 34h reaches the byte written above.
		wr(`SBNS_OFF_CTRL, 32'h1, rs);
		wr(`SBNS_OFF_ADDR, 32'h200, rs);
		peek(1'b0, 8'h34, v);
		cmp("indexed", 32'h80, {24'h0, v});
		wr(`SBNS_OFF_CTRL, 32'h0, rs);
		setff(1'b0, 8'h34);
		wr(`SBNS_OFF_BANK, 32'h0, rs);
		peek(1'b1, 8'h34, v);
		cmp("low access", 32'hFF, {24'h0, v});
		wr(`SBNS_OFF_CTRL, 32'h1, rs);
		setff(1'b0, 8'h60);
		wr(`SBNS_OFF_BANK, 32'hF, rs);
		peek(1'b1, 8'h60, v);
		cmp("high access", 32'hFF, {24'h0, v});
		complete_run();
	end
endmodule : subtract_borrow_nibble_swap_tb
